// file: include/psd_pkg.sv
// Function
// R1: sync enable bit 7 gates sync input; when set PLL follows sync.
// R2: dither field bits 6:5 selects none, one, two or three bits.
// R3: register A6h holds PLL count bits 12:5.
// R4: register A7h bits 7:3 hold PLL count bits 4:0.
// R5: PLL count used only while sync locking enabled; otherwise fixed frequency.
// R6: PLL frequency 5, 10, 20 or 40 MHz from resolution field.
// R7: PLL count equals PLL frequency over sync frequency times factor.
// R8: bit 2 at A7h picks resistor or register field as frequency source.
// R9: bits 1:0 select input hysteresis off, or 11, 10, 8-bit resolution.
// R10: boost code gives 10 V plus 1 V per step, saturating at 40 V.
package psd_pkg;
    localparam logic [7:0] ADDR_SYNC_DITHER_BOOST = 8'hA5;
    localparam logic [7:0] ADDR_PLL_HIGH = 8'hA6;
    localparam logic [7:0] ADDR_PLL_LOW = 8'hA7;
    localparam logic [7:0] RESET_SYNC_DITHER_BOOST = 8'h00;
    localparam logic [7:0] RESET_PLL_HIGH = 8'h00;
    localparam logic [7:0] RESET_PLL_LOW = 8'h00;
    localparam int SYNC_EN_BIT = 7;
    localparam int DITHER_MSB = 6;
    localparam int DITHER_LSB = 5;
    localparam int BOOST_MSB = 4;
    localparam int PLL_LOW_MSB = 7;
    localparam int PLL_LOW_LSB = 3;
    localparam int FREQ_SRC_BIT = 2;
    localparam int HYST_MSB = 1;
    localparam logic [5:0] BOOST_BASE_VOLTS = 6'h0A;
    localparam logic [5:0] BOOST_MAX_VOLTS = 6'h28;
    localparam logic [7:0] FACTOR_5MHZ = 8'h1A;
    localparam logic [7:0] FACTOR_10MHZ = 8'h32;
    localparam logic [7:0] FACTOR_20MHZ = 8'h62;
    localparam logic [7:0] FACTOR_40MHZ = 8'hC4;
    localparam logic [5:0] PLL_MHZ_5 = 6'h05;
    localparam logic [5:0] PLL_MHZ_10 = 6'h0A;
    localparam logic [5:0] PLL_MHZ_20 = 6'h14;
    localparam logic [5:0] PLL_MHZ_40 = 6'h28;
    localparam logic [3:0] HYST_RES_11 = 4'hB;
    localparam logic [3:0] HYST_RES_10 = 4'hA;
    localparam logic [3:0] HYST_RES_8 = 4'h8;
endpackage

// file: rtl/psd_cfg.sv
`timescale 1ns/1ps
module psd_cfg (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // other configuration inputs
    input wire logic [1:0] pwm_resolution,
    input wire logic sync_in,
    // decoded controls, plus the pwm_rate_field input
    output logic pll_sync_active,
    output logic pll_sync_clk,
    output logic [12:0] pll_count,
    output logic [5:0] pll_freq_mhz,
    output logic [7:0] pll_factor,
    output logic [1:0] dither_bits,
    output logic [4:0] boost_target_code,
    output logic [5:0] boost_target_volts,
    output logic freq_resistor_select,
    output logic [4:0] pwm_rate_code,
    input wire logic [4:0] pwm_rate_field,
    output logic hyst_enable,
    output logic [3:0] hyst_resolution
);
    logic rst_meta;
    logic rst_sync_n;
    logic [7:0] sync_dither_boost_cfg;
    logic [7:0] pll_count_high;
    logic [7:0] pll_count_low_freqsrc_hyst;
    logic sync_en;
    logic [4:0] vcode;
    logic [5:0] next_volts;
    logic [12:0] next_pll_count;
    logic [5:0] next_freq_mhz;
    logic [7:0] next_factor;
    logic [3:0] next_hyst_res;

    // register slot of an address, zero when unmapped
    function automatic logic [1:0] reg_index(input logic [7:0] a);
        logic [1:0] idx;
        idx = 2'h0;
        case (a)
            psd_pkg::ADDR_SYNC_DITHER_BOOST: idx = 2'h1;
            psd_pkg::ADDR_PLL_HIGH: idx = 2'h2;
            psd_pkg::ADDR_PLL_LOW: idx = 2'h3;
            default: idx = 2'h0;
        endcase
        return idx;
    endfunction

    // async reset copy released through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sync_dither_boost_cfg <= psd_pkg::RESET_SYNC_DITHER_BOOST;
        end else if (wr_en && reg_index(addr) == 2'h1) begin
            sync_dither_boost_cfg <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_count_high <= psd_pkg::RESET_PLL_HIGH;
        end else if (wr_en && reg_index(addr) == 2'h2) begin
            pll_count_high <= wr_data; // [R3]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_count_low_freqsrc_hyst <= psd_pkg::RESET_PLL_LOW;
        end else if (wr_en && reg_index(addr) == 2'h3) begin
            pll_count_low_freqsrc_hyst <= wr_data; // [R4]
        end
    end

    // read data, unmapped addresses read zero
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rd_data <= 8'h00;
        end else begin
            case (reg_index(addr))
                2'h1: rd_data <= sync_dither_boost_cfg;
                2'h2: rd_data <= pll_count_high;
                2'h3: rd_data <= pll_count_low_freqsrc_hyst;
                default: rd_data <= 8'h00;
            endcase
        end
    end

    assign sync_en = sync_dither_boost_cfg[psd_pkg::SYNC_EN_BIT];
    assign vcode = sync_dither_boost_cfg[psd_pkg::BOOST_MSB:0];

    always_comb begin
        next_volts = psd_pkg::BOOST_BASE_VOLTS + {1'b0, vcode};
        if (next_volts > psd_pkg::BOOST_MAX_VOLTS)
            next_volts = psd_pkg::BOOST_MAX_VOLTS; // [R10]
    end

    // count is zero unless sync locking is on
    always_comb begin
        next_pll_count = 13'h0000;
        if (sync_en)
            next_pll_count = {pll_count_high, pll_count_low_freqsrc_hyst[
                psd_pkg::PLL_LOW_MSB:psd_pkg::PLL_LOW_LSB]}; // [R5]
    end

    always_comb begin
        next_freq_mhz = psd_pkg::PLL_MHZ_40;
        next_factor = psd_pkg::FACTOR_40MHZ;
        case (pwm_resolution) // [R6] [R7]
            2'h0: begin
                next_freq_mhz = psd_pkg::PLL_MHZ_5;
                next_factor = psd_pkg::FACTOR_5MHZ;
            end
            2'h1: begin
                next_freq_mhz = psd_pkg::PLL_MHZ_10;
                next_factor = psd_pkg::FACTOR_10MHZ;
            end
            2'h2: begin
                next_freq_mhz = psd_pkg::PLL_MHZ_20;
                next_factor = psd_pkg::FACTOR_20MHZ;
            end
            default: begin
                next_freq_mhz = psd_pkg::PLL_MHZ_40;
                next_factor = psd_pkg::FACTOR_40MHZ;
            end
        endcase
    end

    always_comb begin
        next_hyst_res = 4'h0;
        case (pll_count_low_freqsrc_hyst[psd_pkg::HYST_MSB:0]) // [R9]
            2'h0: begin
                next_hyst_res = 4'h0;
            end
            2'h1: begin
                next_hyst_res = psd_pkg::HYST_RES_11;
            end
            2'h2: begin
                next_hyst_res = psd_pkg::HYST_RES_10;
            end
            default: begin
                next_hyst_res = psd_pkg::HYST_RES_8;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_sync_active <= 1'b0;
        end else begin
            pll_sync_active <= sync_en; // [R1]
        end
    end

    // sync input reaches the loop only while locking is enabled
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_sync_clk <= 1'b0;
        end else begin
            pll_sync_clk <= sync_en & sync_in; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_count <= 13'h0000;
        end else begin
            pll_count <= next_pll_count; // [R3] [R4] [R5]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pll_freq_mhz <= psd_pkg::PLL_MHZ_5;
            pll_factor <= psd_pkg::FACTOR_5MHZ;
        end else begin
            pll_freq_mhz <= next_freq_mhz; // [R6]
            pll_factor <= next_factor; // [R7]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dither_bits <= 2'h0;
        end else begin
            dither_bits <= sync_dither_boost_cfg
                [psd_pkg::DITHER_MSB:psd_pkg::DITHER_LSB]; // [R2]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            boost_target_code <= 5'h00;
            boost_target_volts <= psd_pkg::BOOST_BASE_VOLTS;
        end else begin
            boost_target_code <= vcode; // [R10]
            boost_target_volts <= next_volts; // [R10]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            freq_resistor_select <= 1'b0;
        end else begin
            freq_resistor_select <=
                pll_count_low_freqsrc_hyst[psd_pkg::FREQ_SRC_BIT]; // [R8]
        end
    end

    // rate code is meaningless while the resistor sets the frequency
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pwm_rate_code <= 5'h00;
        end else begin
            pwm_rate_code <= pll_count_low_freqsrc_hyst[psd_pkg::FREQ_SRC_BIT]
                ? 5'h00 : pwm_rate_field; // [R8]
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hyst_enable <= 1'b0;
            hyst_resolution <= 4'h0;
        end else begin
            hyst_enable <= next_hyst_res != 4'h0; // [R9]
            hyst_resolution <= next_hyst_res; // [R9]
        end
    end
endmodule // psd_cfg

// file: testbench/psd_cfg_chk.sv
`timescale 1ns/1ps
module psd_cfg_chk (
    input wire logic clk, reset_n, wr_en, sync_in, pll_sync_clk,
    input wire logic pll_sync_active, freq_resistor_select, hyst_enable,
    input wire logic [7:0] addr, wr_data, pll_factor,
    input wire logic [1:0] pwm_resolution, dither_bits,
    input wire logic [4:0] pwm_rate_field, pwm_rate_code, boost_target_code,
    input wire logic [12:0] pll_count,
    input wire logic [5:0] pll_freq_mhz, boost_target_volts,
    input wire logic [3:0] hyst_resolution
);
    // design releases its reset two edges late; wait one more for outputs
    logic [2:0] settle;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) settle <= 3'h0;
        else settle <= {settle[1:0], 1'b1};
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!settle[2]);
    property p_sclk; pll_sync_clk == ($past(sync_in) && pll_sync_active);
    endproperty
    a_sclk: assert property (p_sclk) else $error("sync clock");
    property p_dith; wr_en && addr == 8'hA5 ##1 !wr_en
        |-> ##1 dither_bits == $past(wr_data[6:5], 2); endproperty
    a_dith: assert property (p_dith) else $error("dither");
    property p_cnt; !pll_sync_active |-> pll_count == 13'h0000; endproperty
    a_cnt: assert property (p_cnt) else $error("count");
    property p_freq; pll_freq_mhz == (6'h05 << $past(pwm_resolution));
    endproperty
    a_freq: assert property (p_freq) else $error("pll freq");
    property p_fact; pll_factor == (pll_freq_mhz == 6'h05 ? 8'h1A :
        pll_freq_mhz == 6'h0A ? 8'h32 : pll_freq_mhz == 6'h14 ? 8'h62 :
        8'hC4); endproperty
    a_fact: assert property (p_fact) else $error("factor");
    property p_rate; pwm_rate_code ==
        (freq_resistor_select ? 5'h00 : $past(pwm_rate_field)); endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_hyst; hyst_enable == (hyst_resolution != 4'h0) &&
        hyst_resolution inside {4'h0, 4'hB, 4'hA, 4'h8}; endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis");
    property p_volt; boost_target_volts == (boost_target_code > 5'h1D ?
        6'h28 : {1'b0, boost_target_code} + 6'h0A); endproperty
    a_volt: assert property (p_volt) else $error("boost volts");
    c_sync: cover property (pll_sync_active && pll_count != 13'h0000);
    c_volt: cover property (boost_target_volts == 6'h28);
    c_hyst: cover property (hyst_resolution == 4'hA);
endmodule // psd_cfg_chk
bind psd_cfg psd_cfg_chk psd_cfg_chk_inst (.*);

// file: testbench/psd_host.sv
`timescale 1ns/1ps
module psd_host (
    // register port
    input wire logic clk,
    output logic wr_en = 1'b0,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] wr_data = 8'h00
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    // read data lands one edge after the address, let it settle
    task automatic sel(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule // psd_host

// file: testbench/psd_cfg_tb.sv
`timescale 1ns/1ps
module psd_cfg_tb;
    logic clk = 1'b0, reset_n = 1'b0, sync_in = 1'b0, wr_en;
    logic pll_sync_active, pll_sync_clk, freq_resistor_select, hyst_enable;
    logic [1:0] pwm_resolution = 2'h0, dither_bits;
    logic [4:0] pwm_rate_field = 5'h00, pwm_rate_code, boost_target_code;
    logic [7:0] addr, wr_data, rd_data, pll_factor;
    logic [12:0] pll_count;
    logic [5:0] pll_freq_mhz, boost_target_volts;
    logic [3:0] hyst_resolution;
    int num_errors = 0, samples_checked = 0;
    initial forever #4 clk = ~clk;
    psd_host psd_host_inst (.*);
    psd_cfg psd_cfg_inst (.*);
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic summarize;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        pwm_rate_field <= 5'h15;
        repeat (3) @(posedge clk);
        for (int a = 8'hA5; a < 8'hA9; a++) begin
            psd_host_inst.sel(a[7:0]);
            chk("reset read", 16'h0, rd_data);
        end
        psd_host_inst.wr(8'hA5, 8'hFF);
        // count for 60 Hz sync at a 5 MHz loop
        psd_host_inst.wr(8'hA6, 8'h64);
        psd_host_inst.wr(8'hA7, 8'h2D);
        psd_host_inst.wr(8'hA8, 8'h00);
        psd_host_inst.sel(8'hA5);
        chk("a5", 16'hFF, rd_data);
        chk("dither", 16'h3, dither_bits);
        chk("count", 16'h0C85, pll_count);
        chk("rate", 16'h0, pwm_rate_code);
        chk("hyst", 16'hB, hyst_resolution);
        chk("volts", 16'h28, boost_target_volts);
        chk("code", 16'h1F, boost_target_code);
        chk("res sel", 16'h1, freq_resistor_select);
        chk("hyst en", 16'h1, hyst_enable);
        chk("sync on", 16'h1, pll_sync_active);
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            pwm_resolution <= r[1:0];
            sync_in <= r[0];
            repeat (2) @(posedge clk);
            #1;
            chk("mhz", 16'h5 << r, pll_freq_mhz);
            chk("factor", r == 0 ? 16'd26 : r == 1 ? 16'd50 :
                r == 2 ? 16'd98 : 16'd196, pll_factor);
            chk("sync clk", r[0] ? 16'h1 : 16'h0, pll_sync_clk);
        end
        psd_host_inst.wr(8'hA5, 8'h41);
        psd_host_inst.wr(8'hA7, 8'h2A);
        psd_host_inst.sel(8'hA6);
        chk("a6", 16'h64, rd_data);
        chk("count off", 16'h0, pll_count);
        chk("dither", 16'h2, dither_bits);
        chk("volts", 16'h0B, boost_target_volts);
        chk("rate", 16'h15, pwm_rate_code);
        chk("hyst", 16'hA, hyst_resolution);
        chk("sync off", 16'h0, pll_sync_active);
        chk("res sel", 16'h0, freq_resistor_select);
        summarize();
    end
endmodule // psd_cfg_tb
